// ---- bench/tmic_core_model.sv ----
// Purpose: Behavioural CPU core that answers the controller's calls
// Assumes: Call request is held until call_done is sampled
// Notes:   dly_in sets a prompt or slow answer per call
`timescale 1ns/1ps
`default_nettype none
module tmic_core_model (
   input  wire logic       clk_in,
   input  wire logic       call_req_in,
   input  wire logic       exit_en_sel_in,
   input  wire logic [3:0] dly_in,
   output logic            call_done_out,
   output logic            isr_exit_out,
   output logic            plain_exit_out
);
   // ---------------------------------
   // Push, branch, then return
   // ---------------------------------
   initial begin
      call_done_out = 1'b0;
      isr_exit_out = 1'b0;
      plain_exit_out = 1'b0;
      forever begin
         @(posedge clk_in);
         if (call_req_in === 1'b1) begin
            repeat (dly_in) @(posedge clk_in);
            call_done_out <= 1'b1;
            @(posedge clk_in);
            call_done_out <= 1'b0;
            @(posedge clk_in);
            isr_exit_out <= exit_en_sel_in;
            plain_exit_out <= !exit_en_sel_in;
            @(posedge clk_in);
            isr_exit_out <= 1'b0;
            plain_exit_out <= 1'b0;
         end
      end
   end
endmodule : tmic_core_model
`default_nettype wire

// ---- bench/tmic_ctrl_tb.sv ----
// Purpose: Self-checking bench of the interrupt controller
// Assumes: Registers reached by classic Wishbone, one access at a time
// Notes:   Expected reads and vectors are queued by the driver
`timescale 1ns/1ps
`default_nettype none
module tmic_ctrl_tb;
   import tmic_pkg::*;
   logic clk, rst, cyc, stb, we, phase, sfull, halt, idl, onh, hls, exit_en;
   logic wk, fg;
   int n_wake = 0;
   logic [7:0]  adr, evl;
   logic [31:0] dat, rdat;
   logic [3:0]  dly;
   logic ack, creq, pco, done, iex, pex, req_q;
   logic [7:0]  vec;
   logic [7:0]  vq[$];
   logic [7:0]  rq[$];
   int n_errors = 0, num_checks = 0, cyc_n = 0, seed = 94484;
   logic [31:0] d;

   tmic_ctrl dut (.ref_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(dat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .external_irq_pin_in(evl[0]),
      .timer0_ovf_in(evl[1]), .timer1_ovf_in(evl[2]), .fsk_event_in(evl[3]),
      .rtc_tick_in(evl[4]), .hook_switch_input_in(evl[5]),
      .hands_free_input_in(evl[6]), .hold_line_input_in(evl[7]),
      .on_hook_state_in(onh), .hold_line_state_in(hls),
      .second_clock_phase_in(phase), .stack_full_in(sfull), .call_done_in(done),
      .isr_exit_with_enable_in(iex), .plain_subroutine_exit_in(pex), .halt_in(halt),
      .idle_select_in(idl), .call_req_out(creq), .call_vector_out(vec),
      .push_pc_only_out(pco), .wake_out(wk), .force_green_out(fg));
   tmic_core_model core (.clk_in(clk), .call_req_in(creq), .exit_en_sel_in(exit_en),
      .dly_in(dly), .call_done_out(done), .isr_exit_out(iex), .plain_exit_out(pex));

   // ---------------------------------
   // Checking and closing
   // ---------------------------------
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check

   task automatic conclude;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   // Results are compared in the cycle they stand
   always @(posedge clk) begin
      req_q <= creq;
      cyc_n <= cyc_n + 1;
      if (creq === 1'b1 && req_q !== 1'b1) begin
         check({24'h0, vec}, vq.size() ? {24'h0, vq.pop_front()} : 32'hee);
         check({31'h0, pco}, 32'h1);
      end
      if (ack === 1'b1 && we === 1'b0)
         check(rdat, rq.size() ? {24'h0, rq.pop_front()} : 32'hee);
      if (wk === 1'b1) begin
         n_wake++;
         check({31'h0, fg}, 32'h1);
      end
      if (cyc_n == 20000) begin
         n_errors++;
         conclude();
      end
   end

   // ---------------------------------
   // Drivers
   // ---------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, v};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      bus(1'b1, a, v);
   endtask : wr

   // Two toggles: an edge of each sense reaches the synchroniser
   task automatic pulse(input int i);
      evl[i] <= !evl[i];
      repeat (3) @(posedge clk);
      evl[i] <= !evl[i];
      repeat (6) @(posedge clk);
   endtask : pulse

   task automatic tick;
      phase <= 1'b1;
      repeat (2) @(posedge clk);
      phase <= 1'b0;
      @(posedge clk);
   endtask : tick

   task automatic serve;
      for (int i = 0; i < 30 && creq !== 1'b1; i++) @(posedge clk);
      for (int i = 0; i < 30 && creq !== 1'b0; i++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask : serve

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ---------------------------------
   // Scenarios
   // ---------------------------------
   initial begin
      {rst, cyc, stb, we, phase, sfull, halt, idl, onh, hls, exit_en} = 11'h401;
      {adr, dat, evl, dly} = {8'h00, 32'h0, 8'ha1, 4'h1};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h0b, 8'h00);
      rd(8'h1e, 8'h00);
      wr(8'h7f, 8'hff);
      rd(8'h7f, 8'h00);
      for (int k = 0; k < 4; k++) begin
         d = $random(seed);
         wr(8'h0b, d[7:0] & 8'hfe);
         rd(8'h0b, d[7:0] & 8'h7e);
         wr(8'h1e, d[15:8]);
         rd(8'h1e, d[15:8] & 8'h77);
      end
      for (int i = 0; i < 8; i++) begin
         wr(8'h0b, 8'h00);
         wr(8'h1e, 8'h00);
         pulse(i);
         rd(i < 3 ? 8'h0b : 8'h1e, 8'h10 << (i < 3 ? i : (i < 5 ? i - 3 : 2)));
      end
      {onh, hls} <= 2'b11;
      wr(8'h1e, 8'h00);
      pulse(7);
      rd(8'h1e, 8'h00);
      {onh, hls} <= 2'b00;
      wr(8'h1e, 8'h04);
      {idl, halt} <= 2'b11;
      @(posedge clk);
      halt <= 1'b0;
      rd(8'h41, 8'h01);
      pulse(5);
      rd(8'h1e, 8'h04);
      wr(8'h0b, 8'h24);
      repeat (4) @(posedge clk);
      rd(8'h41, 8'h00);
      wr(8'h1e, 8'h77);
      wr(8'h0b, 8'h7f);
      for (int i = 0; i < 6; i++) begin
         dly <= 4'(1 + ($random(seed) & 7));
         vq.push_back(8'h04 + 8'(4 * i));
         tick();
         serve();
      end
      rd(8'h0b, 8'h0f);
      rd(8'h1e, 8'h07);
      exit_en <= 1'b0;
      wr(8'h0b, 8'h13);
      vq.push_back(8'h04);
      tick();
      serve();
      rd(8'h0b, 8'h02);
      exit_en <= 1'b1;
      sfull <= 1'b1;
      wr(8'h0b, 8'h13);
      tick();
      repeat (10) @(posedge clk);
      rd(8'h0b, 8'h13);
      sfull <= 1'b0;
      vq.push_back(8'h04);
      tick();
      serve();
      wr(8'h0b, 8'h13);
      vq.push_back(8'h04);
      wr(8'h40, 8'h01);
      serve();
      rd(8'h40, 8'h01);
      check(n_wake, 1);
      check(vq.size(), 0);
      conclude();
   end
endmodule : tmic_ctrl_tb
`default_nettype wire

// ---- core/tmic_consts.svh ----
// Purpose: Offsets, field positions, reset values and vectors of the interrupt controller
// Assumes: Included by the controller
// Notes:   Definitions only
`ifndef TMIC_CONSTS_SVH
`define TMIC_CONSTS_SVH

`define TMIC_IDX_PRIMARY     8'h0b
`define TMIC_IDX_SECONDARY   8'h1e
`define TMIC_IDX_CORE        8'h40
`define TMIC_IDX_STATUS      8'h41

`define TMIC_BIT_MASTER      0
`define TMIC_BIT_EN_LO       1
`define TMIC_BIT_FLAG_LO     4

`define TMIC_RST_PRIMARY     8'h00
`define TMIC_RST_SECONDARY   8'h00
`define TMIC_RST_CORE        8'h00
`define TMIC_RST_PINS        7'h03

`define TMIC_VEC_BASE        8'h04
`define TMIC_VEC_STEP        8'h04

`define TMIC_CORE_BIT_PHASE  0
`define TMIC_CORE_BIT_IDLE   1
`define TMIC_CORE_BIT_SLEEP  2

`endif

// ---- core/tmic_ctrl.sv ----
// Purpose: Six-source interrupt controller of a telephone microcontroller
// Assumes: Classic Wishbone slave, one clock, core strobes are synchronous
// Notes:   Pin and peripheral event lines are two-flop synchronised
//
// Notes on behaviour
// - Falling edge of external pin sets its flag; enabled, room, calls 04H.
// - Timer 0 overflow sets its flag; enabled, room, calls 08H.
// - Timer 1 overflow sets its flag; enabled, room, calls 0CH.
// - Ring, reversal, carrier or packet byte sets peripheral flag; calls 10H.
// - Each 1Hz tick sets the tick flag; enabled, room, calls 14H.
// - Hook any edge, hold fall, hands-free rise set dialer flag; calls 18H.
// - Hold fall ignored while on-hook and hold-line both active.
// - Dialer source inhibited while the mode is Idle.
// - Acceptance clears master enable and the serviced flag.
// - Requests while blocked only set their flags.
// - Master plus source enable set in a routine allows nesting.
// - No acknowledge while the stack is full.
// - Only the program counter is pushed before branching to the vector.
// - Interrupt return sets master enable; plain return leaves it.
// - Requests between two phase pulses are serviced at the later pulse.
// - Fixed priority: external, timer 0, timer 1, peripheral, tick, dialer.
// - Flags hold until serviced or cleared by software.
// - Every source can wake the device from halt, except the dialer while the mode is Idle.
// - Primary: master bit 0, enables 1-3, flags 4-6, bit 7 zero.
// - Secondary: enables 0-2, flags 4-6, bits 3 and 7 zero.
// - A wake from Sleep or Idle forces the mode to Green.
`include "tmic_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tmic_ctrl
   import tmic_pkg::*;
#(
   parameter int NSRC = 6
) (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   input  wire logic       wb_cyc_in,
   input  wire logic       wb_stb_in,
   input  wire logic       wb_we_in,
   input  wire logic [7:0] wb_adr_in,
   input  wire logic [3:0] wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic            wb_ack_out,
   input  wire logic       external_irq_pin_in,
   input  wire logic       hook_switch_input_in,
   input  wire logic       hold_line_input_in,
   input  wire logic       hands_free_input_in,
   input  wire logic       timer0_ovf_in,
   input  wire logic       timer1_ovf_in,
   input  wire logic       fsk_event_in,
   input  wire logic       rtc_tick_in,
   input  wire logic       on_hook_state_in,
   input  wire logic       hold_line_state_in,
   input  wire logic       second_clock_phase_in,
   input  wire logic       stack_full_in,
   input  wire logic       call_done_in,
   input  wire logic       isr_exit_with_enable_in,
   input  wire logic       plain_subroutine_exit_in,
   input  wire logic       halt_in,
   input  wire logic       idle_select_in,
   output logic            call_req_out,
   output logic      [7:0] call_vector_out,
   output logic            push_pc_only_out,
   output logic            wake_out,
   output logic            force_green_out
);

   generate
      if (NSRC != 6) begin : g_bad_nsrc
         $error("tmic_ctrl serves exactly six sources");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int NPIN = 7;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1_q;
   logic [NPIN-1:0] sync2_q;
   logic [NPIN-1:0] prev_q;
   assign pin_raw = {fsk_event_in, rtc_tick_in, timer1_ovf_in, timer0_ovf_in,
                     hands_free_input_in, hold_line_input_in, hook_switch_input_in};
   logic ext_s1_q, ext_s2_q, ext_prev_q;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         // Hook and hold pins idle high; starting at that level avoids a false edge
         sync1_q    <= `TMIC_RST_PINS;
         sync2_q    <= `TMIC_RST_PINS;
         prev_q     <= `TMIC_RST_PINS;
         ext_s1_q   <= 1'b1;
         ext_s2_q   <= 1'b1;
         ext_prev_q <= 1'b1;
      end else begin
         sync1_q    <= pin_raw;
         sync2_q    <= sync1_q;
         prev_q     <= sync2_q;
         ext_s1_q   <= external_irq_pin_in;
         ext_s2_q   <= ext_s1_q;
         ext_prev_q <= ext_s2_q;
      end
   end

   // ----------------------------------------------------------------
   // Source events
   // ----------------------------------------------------------------
   tmic_mode_t mode_q;
   logic [NSRC-1:0] evt;
   logic hold_fall_ok;
   assign hold_fall_ok = !(on_hook_state_in && hold_line_state_in);
   assign evt[0] = ext_prev_q & ~ext_s2_q;
   assign evt[1] = sync2_q[3] & ~prev_q[3];
   assign evt[2] = sync2_q[4] & ~prev_q[4];
   assign evt[3] = sync2_q[6] & ~prev_q[6];
   assign evt[4] = sync2_q[5] & ~prev_q[5];
   assign evt[5] = (mode_q != TMIC_IDLE) &&
                   ((sync2_q[0] ^ prev_q[0]) ||
                    (prev_q[1] & ~sync2_q[1] & hold_fall_ok) ||
                    (sync2_q[2] & ~prev_q[2]));

   // ----------------------------------------------------------------
   // Register bus decode
   // ----------------------------------------------------------------
   logic [NSRC-1:0] en_q;
   logic [NSRC-1:0] flag_q;
   logic            master_q;
   logic [7:0]      core_q;
   tmic_seq_t       seq_q;
   logic            ack_q;
   logic            bus_req, wr_pri, wr_sec, wr_core, lane0;
   assign bus_req = wb_cyc_in & wb_stb_in & ~ack_q;
   assign lane0   = wb_sel_in[0];
   assign wr_pri  = bus_req & wb_we_in & lane0 & (wb_adr_in == `TMIC_IDX_PRIMARY);
   assign wr_sec  = bus_req & wb_we_in & lane0 & (wb_adr_in == `TMIC_IDX_SECONDARY);
   assign wr_core = bus_req & wb_we_in & lane0 & (wb_adr_in == `TMIC_IDX_CORE);

   logic [7:0] rd_pri, rd_sec, rd_stat, rd_byte;
   assign rd_pri  = {1'b0, flag_q[2:0], en_q[2:0], master_q};
   assign rd_sec  = {1'b0, flag_q[5:3], 1'b0, en_q[5:3]};
   assign rd_stat = {4'h0, stack_full_in, (seq_q != TMIC_WAIT), mode_q};
   assign rd_byte = (wb_adr_in == `TMIC_IDX_PRIMARY)   ? rd_pri  :
                    (wb_adr_in == `TMIC_IDX_SECONDARY) ? rd_sec  :
                    (wb_adr_in == `TMIC_IDX_CORE)      ? core_q  :
                    (wb_adr_in == `TMIC_IDX_STATUS)    ? rd_stat : 8'h00;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_q      <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
         core_q     <= `TMIC_RST_CORE;
      end else begin
         ack_q      <= bus_req;
         wb_dat_out <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         if (wr_core) core_q <= wb_dat_in[7:0];
      end
   end
   assign wb_ack_out = ack_q;

   // ----------------------------------------------------------------
   // Phase sampling and arbitration
   // ----------------------------------------------------------------
   logic ph_s1_q, ph_s2_q, ph_prev_q;
   logic phase_rise;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ph_s1_q   <= 1'b0;
         ph_s2_q   <= 1'b0;
         ph_prev_q <= 1'b0;
      end else begin
         ph_s1_q   <= second_clock_phase_in;
         ph_s2_q   <= ph_s1_q;
         ph_prev_q <= ph_s2_q;
      end
   end
   // Software may pulse the phase through the core register for bench use
   assign phase_rise = (ph_s2_q & ~ph_prev_q) | (wr_core & wb_dat_in[`TMIC_CORE_BIT_PHASE]);

   logic [NSRC-1:0] active;
   logic [NSRC-1:0] grant;
   logic [NSRC-1:0] lower;
   assign active = flag_q & en_q;
   assign lower[0] = 1'b0;
   genvar gi;
   generate
      for (gi = 1; gi < NSRC; gi++) begin : g_pri
         assign lower[gi] = lower[gi-1] | active[gi-1];
      end
      for (gi = 0; gi < NSRC; gi++) begin : g_gnt
         assign grant[gi] = active[gi] & ~lower[gi];
      end
   endgenerate

   logic            accept;
   logic [2:0]      grant_idx;
   always_comb begin
      grant_idx = 3'd0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (grant[i]) grant_idx = 3'(i);
      end
   end
   // Only at a phase edge, with master on, stack room and no call pending
   assign accept = phase_rise & master_q & ~stack_full_in
                   & (|active) & (seq_q == TMIC_WAIT);

   // ----------------------------------------------------------------
   // Flags, enables and the call handshake
   // ----------------------------------------------------------------
   logic [NSRC-1:0] sw_flag, sw_flag_we, sw_en, sw_en_we;
   assign sw_flag    = {wb_dat_in[6:4], wb_dat_in[6:4]};
   assign sw_en      = {wb_dat_in[2:0], wb_dat_in[3:1]};
   assign sw_flag_we = {{3{wr_sec}}, {3{wr_pri}}};
   assign sw_en_we   = {{3{wr_sec}}, {3{wr_pri}}};

   logic [NSRC-1:0] clr_grant;
   assign clr_grant = accept ? grant : '0;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flag_q <= '0;
         en_q   <= '0;
      end else begin
         for (int i = 0; i < NSRC; i++) begin
            // Hardware set wins over both software and acceptance clear
            if (evt[i]) flag_q[i] <= 1'b1;
            else if (clr_grant[i]) flag_q[i] <= 1'b0;
            else if (sw_flag_we[i]) flag_q[i] <= sw_flag[i];
            if (sw_en_we[i]) en_q[i] <= sw_en[i];
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) master_q <= 1'b0;
      else if (accept) master_q <= 1'b0;
      else if (isr_exit_with_enable_in) master_q <= 1'b1;
      else if (wr_pri) master_q <= wb_dat_in[`TMIC_BIT_MASTER];
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         seq_q           <= TMIC_WAIT;
         call_req_out    <= 1'b0;
         call_vector_out <= 8'h00;
         push_pc_only_out <= 1'b0;
      end else begin
         case (seq_q)
            TMIC_WAIT: if (accept) begin
               seq_q            <= TMIC_CALL;
               call_req_out     <= 1'b1;
               push_pc_only_out <= 1'b1;
               call_vector_out  <= 8'(`TMIC_VEC_BASE
                                    + `TMIC_VEC_STEP * grant_idx);
            end
            TMIC_CALL: if (call_done_in) begin
               seq_q            <= TMIC_WAIT;
               call_req_out     <= 1'b0;
               push_pc_only_out <= 1'b0;
            end
            default: seq_q <= TMIC_WAIT;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Operating mode and wake
   // ----------------------------------------------------------------
   logic any_pending;
   assign any_pending = |active;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_q          <= TMIC_RUN;
         wake_out        <= 1'b0;
         force_green_out <= 1'b0;
      end else begin
         wake_out        <= 1'b0;
         force_green_out <= 1'b0;
         if (mode_q != TMIC_RUN && any_pending) begin
            mode_q          <= TMIC_RUN;
            wake_out        <= 1'b1;
            force_green_out <= 1'b1;
         end else if (halt_in && mode_q == TMIC_RUN) begin
            mode_q <= idle_select_in ? TMIC_IDLE : TMIC_SLEEP;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_full_blocks_call: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (stack_full_in && seq_q == TMIC_WAIT) |=> !call_req_out)
      else $error("call raised while stack full");
   chk_accept_clears_master: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      accept |=> !master_q && call_req_out)
      else $error("master enable survived acceptance");
   chk_ext_vector: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (accept && active[0]) |=> call_vector_out == 8'h04)
      else $error("external not first");
   chk_dialer_vector: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (accept && active == 6'b100000) |=> call_vector_out == 8'h18)
      else $error("dialer vector wrong");
   chk_retn_sets: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (isr_exit_with_enable_in && !accept) |=> master_q)
      else $error("interrupt return left master off");
   chk_idle_dialer: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (mode_q == TMIC_IDLE && !flag_q[5] && !wr_sec) |=> !flag_q[5])
      else $error("dialer event in idle");
   chk_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (flag_q[0] && !clr_grant[0] && !wr_pri) |=> flag_q[0])
      else $error("flag dropped by itself");
   chk_phase_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ($rose(call_req_out)) |-> $past(phase_rise))
      else $error("call outside phase edge");
   chk_wake_green: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (mode_q != TMIC_RUN && any_pending) |=> force_green_out && mode_q == TMIC_RUN)
      else $error("wake did not force green");
   chk_plain_keeps: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (plain_subroutine_exit_in && !isr_exit_with_enable_in && !accept && !wr_pri)
      |=> master_q == $past(master_q))
      else $error("plain return changed master enable");
   chk_call_holds: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (call_req_out && !call_done_in) |=> call_req_out)
      else $error("call request dropped before done");
   chk_timer0_vector: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (accept && active[1:0] == 2'b10) |=> call_vector_out == 8'h08)
      else $error("timer 0 vector wrong");

   // A call is two steps: acceptance, then request, vector and pc push together
   sequence s_call_accept;
      accept && seq_q == TMIC_WAIT;
   endsequence
   sequence s_call_raised;
      call_req_out && push_pc_only_out && !master_q;
   endsequence
   chk_call_sequence: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_call_accept |=> s_call_raised)
      else $error("call raised without pc push");

endmodule : tmic_ctrl

`default_nettype wire

// ---- core/tmic_pkg.sv ----
// Purpose: Types of the interrupt controller
// Assumes: Nothing
// Notes:   Numbers live in tmic_consts.svh
package tmic_pkg;
   typedef enum logic [1:0] {TMIC_RUN, TMIC_IDLE, TMIC_SLEEP} tmic_mode_t;
   typedef enum logic [1:0] {TMIC_WAIT, TMIC_CALL, TMIC_SERVE} tmic_seq_t;
endpackage : tmic_pkg
